// >>> logic/pace_port_params.svh
// timing constants, field positions and reset values of the pace-detection serial port
`ifndef PACE_PORT_PARAMS_SVH
`define PACE_PORT_PARAMS_SVH

`define SYS_CLK_PERIOD_PS    4000
`define PORT_CLK_HALF_PS     24414
`define PORT_CLK_HALF_CYCLES (`PORT_CLK_HALF_PS / `SYS_CLK_PERIOD_PS)
`define FRAME_PERIOD_PS      7812500
`define FRAME_CYCLES         (`FRAME_PERIOD_PS / `SYS_CLK_PERIOD_PS)
`define SELECT_HOLD_HALVES   2
`define WORD_BITS            16
`define WORDS_PER_FRAME      7
`define ACQ_CTL_WIDTH        8
`define ACQ_CTL_HIGH_PERF    3
`define HEADER_WORD_DEFAULT  16'h8000
`define CRC_INIT             16'hffff
`define CRC_POLY             16'h1021

`endif

// >>> logic/pace_port_pkg.sv
// types shared by the pace-detection serial port
package pace_port_pkg;

  typedef struct packed {
    logic [15:0] channel_one_word;
    logic [15:0] channel_two_word;
    logic [15:0] channel_three_word;
  } ecg_sample_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_SETUP = 3'b001,
    ST_LOW   = 3'b011,
    ST_HIGH  = 3'b010,
    ST_HOLD  = 3'b110,
    ST_GAP   = 3'b111
  } port_state_t;

endpackage : pace_port_pkg

// >>> logic/frame_crc16.sv
// serial crc-16 over the bits of one frame
`timescale 1ns/1ps
`include "pace_port_params.svh"

module frame_crc16 (
  // clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        arst_n_in,
  // bit stream
  input  wire logic        clear_in,
  input  wire logic        shift_in,
  input  wire logic        bit_in,
  // result
  output logic [15:0]      crc_out
);

  logic fb;

  assign fb = bit_in ^ crc_out[15];

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      crc_out <= `CRC_INIT;
    end else if (clear_in) begin
      crc_out <= `CRC_INIT;
    end else if (shift_in) begin
      crc_out <= {crc_out[14:0], 1'b0} ^ (fb ? `CRC_POLY : 16'h0000);
    end
  end

endmodule : frame_crc16

// >>> logic/pace_port_master.sv
// serial master that streams ecg frames to an external pace-detection processor
`timescale 1ns/1ps
`include "pace_port_params.svh"

module pace_port_master
  import pace_port_pkg::*;
#(
  parameter int          HALF_CYCLES  = `PORT_CLK_HALF_CYCLES,
  parameter int          FRAME_CYCLES = `FRAME_CYCLES,
  parameter logic [15:0] HEADER_WORD  = `HEADER_WORD_DEFAULT
) (
  // clock and reset
  input  wire logic                      clk_sys_in,
  input  wire logic                      arst_n_in,
  // control
  input  wire logic [`ACQ_CTL_WIDTH-1:0] acquisition_control_in,
  input  wire logic                      per_word_select_mode_in,
  // sample source
  input  wire ecg_sample_t               sample_in,
  // serial port
  output logic                           pace_port_select_n_out,
  output logic                           pace_port_clock_out,
  output logic                           pace_port_data_out,
  // status
  output logic                           frame_start_out
);

  port_state_t state_q;
  logic [11:0] frame_cnt_q;
  logic [7:0]  div_cnt_q;
  logic [3:0]  bit_cnt_q;
  logic [2:0]  word_cnt_q;
  logic [1:0]  hold_cnt_q;
  logic [15:0] shift_q;
  logic        per_word_q;
  ecg_sample_t sample_q;
  logic        frame_tick;
  logic        half_tick;
  logic        start;
  logic        last_bit;
  logic        crc_shift;
  logic [15:0] crc_value;
  logic [15:0] next_word;

  // terminal counts of the counters
  localparam logic [11:0] FRAME_LAST = 12'(FRAME_CYCLES - 1);
  localparam logic [7:0]  HALF_LAST  = 8'(HALF_CYCLES - 1);
  localparam logic [3:0]  BIT_LAST   = 4'(`WORD_BITS - 1);
  localparam logic [2:0]  WORD_LAST  = 3'(`WORDS_PER_FRAME - 1);
  localparam logic [1:0]  HOLD_LAST  = 2'(`SELECT_HOLD_HALVES - 1);

  // frame timer free-running at the frame rate
  assign frame_tick = (frame_cnt_q == FRAME_LAST);
  assign start      = frame_tick && (state_q == ST_IDLE)
                      && acquisition_control_in[`ACQ_CTL_HIGH_PERF];
  assign half_tick  = (state_q != ST_IDLE) && (div_cnt_q == HALF_LAST);
  assign last_bit   = (bit_cnt_q == BIT_LAST);
  assign crc_shift  = half_tick && ((state_q == ST_SETUP) || (state_q == ST_HIGH))
                      && (word_cnt_q < WORD_LAST);

  // word order within a packet
  always_comb begin
    case (word_cnt_q)
      3'h0:    next_word = sample_q.channel_one_word;
      3'h1:    next_word = sample_q.channel_two_word;
      3'h2:    next_word = sample_q.channel_three_word;
      3'h5:    next_word = crc_value;
      default: next_word = 16'h0000;
    endcase
  end

  // frame timer counter
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      frame_cnt_q <= 12'h000;
    end else if (frame_tick) begin
      frame_cnt_q <= 12'h000;
    end else begin
      frame_cnt_q <= frame_cnt_q + 12'h001;
    end
  end

  // half-period divider for the port clock
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      div_cnt_q <= 8'h00;
    end else if (start || half_tick) begin
      div_cnt_q <= 8'h00;
    end else if (state_q != ST_IDLE) begin
      div_cnt_q <= div_cnt_q + 8'h01;
    end
  end

  // frame contents and mode captured at start
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sample_q   <= '0;
      per_word_q <= 1'b0;
    end else if (start) begin
      sample_q   <= sample_in;
      per_word_q <= per_word_select_mode_in;
    end
  end

  // start strobe for status
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      frame_start_out <= 1'b0;
    end else begin
      frame_start_out <= start;
    end
  end

  // half-period count for word gap and final select hold
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      hold_cnt_q <= 2'h0;
    end else if (state_q == ST_LOW) begin
      hold_cnt_q <= 2'h0;
    end else if (half_tick && ((state_q == ST_GAP) || (state_q == ST_HOLD))) begin
      hold_cnt_q <= hold_cnt_q + 2'h1;
    end
  end

  // sequencer
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_q                <= ST_IDLE;
      bit_cnt_q              <= 4'h0;
      word_cnt_q             <= 3'h0;
      shift_q                <= 16'h0000;
      pace_port_select_n_out <= 1'b1;
      pace_port_clock_out    <= 1'b1;
      pace_port_data_out     <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (start) begin
            state_q                <= ST_SETUP;
            bit_cnt_q              <= 4'h0;
            word_cnt_q             <= 3'h0;
            shift_q                <= HEADER_WORD;
            pace_port_data_out     <= HEADER_WORD[15];
            pace_port_select_n_out <= 1'b0;
          end
        end
        ST_SETUP, ST_HIGH: begin
          if (half_tick) begin
            state_q             <= ST_LOW;
            pace_port_clock_out <= 1'b0;
          end
        end
        ST_LOW: begin
          if (half_tick) begin
            pace_port_clock_out <= 1'b1;
            if (!last_bit) begin
              state_q            <= ST_HIGH;
              bit_cnt_q          <= bit_cnt_q + 4'h1;
              shift_q            <= {shift_q[14:0], 1'b0};
              pace_port_data_out <= shift_q[14];
            end else if (word_cnt_q == WORD_LAST) begin
              state_q <= ST_HOLD;
            end else if (per_word_q) begin
              state_q <= ST_GAP;
            end else begin
              state_q            <= ST_HIGH;
              bit_cnt_q          <= 4'h0;
              word_cnt_q         <= word_cnt_q + 3'h1;
              shift_q            <= next_word;
              pace_port_data_out <= next_word[15];
            end
          end
        end
        ST_GAP: begin
          if (half_tick) begin
            if (hold_cnt_q == 2'h0) begin
              pace_port_select_n_out <= 1'b1;
            end else begin
              state_q                <= ST_SETUP;
              bit_cnt_q              <= 4'h0;
              word_cnt_q             <= word_cnt_q + 3'h1;
              shift_q                <= next_word;
              pace_port_data_out     <= next_word[15];
              pace_port_select_n_out <= 1'b0;
            end
          end
        end
        ST_HOLD: begin
          if (half_tick) begin
            if (hold_cnt_q == HOLD_LAST) begin
              state_q                <= ST_IDLE;
              pace_port_select_n_out <= 1'b1;
              pace_port_data_out     <= 1'b0;
            end
          end
        end
        default: begin
          state_q                <= ST_IDLE;
          pace_port_select_n_out <= 1'b1;
          pace_port_clock_out    <= 1'b1;
        end
      endcase
    end
  end

  // crc over header, ecg words and the two zero words
  frame_crc16 u_crc (
    .clk_sys_in (clk_sys_in),
    .arst_n_in  (arst_n_in),
    .clear_in   (start),
    .shift_in   (crc_shift),
    .bit_in     (pace_port_data_out),
    .crc_out    (crc_value)
  );

endmodule : pace_port_master

// >>> testbench/pace_port_props.sv
// assertions on the pace port master outputs
`timescale 1ns/1ps
module pace_port_props #(
  parameter int HALF_CYCLES  = 6,
  parameter int FRAME_CYCLES = 1953
) (
  // clock and reset
  input wire logic       clk_sys_in,
  input wire logic       arst_n_in,
  // watched ports
  input wire logic [7:0] acquisition_control_in,
  input wire logic       pace_port_select_n_out,
  input wire logic       pace_port_clock_out,
  input wire logic       pace_port_data_out,
  input wire logic       frame_start_out
);
  int   gap_q;
  int   falls_q;
  logic seen_q;
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      gap_q <= 0;
      seen_q <= 1'b0;
    end else begin
      gap_q <= frame_start_out ? 1 : gap_q + 1;
      seen_q <= seen_q | frame_start_out;
    end
  end
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in)
      falls_q <= 0;
    else if ($rose(pace_port_select_n_out))
      falls_q <= 0;
    else if ($fell(pace_port_clock_out))
      falls_q <= falls_q + 1;
  end
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!arst_n_in);
  a_start_when_enabled: assert property (
    frame_start_out |-> $past(acquisition_control_in[3])) else $error("start while disabled");
  a_frame_period: assert property (
    frame_start_out && seen_q |-> gap_q % FRAME_CYCLES == 0) else $error("frame period off");
  a_select_at_start: assert property (
    frame_start_out |-> $fell(pace_port_select_n_out)) else $error("select not low at start");
  a_data_on_rise: assert property (
    !pace_port_select_n_out && $past(!pace_port_select_n_out) && $changed(pace_port_data_out)
    |-> $rose(pace_port_clock_out)) else $error("data moved off rising edge");
  a_clock_idle_high: assert property (
    pace_port_select_n_out |-> pace_port_clock_out) else $error("clock low while deselected");
  a_word_gap_high: assert property (
    $fell(pace_port_select_n_out) && !frame_start_out
    |-> $past(pace_port_clock_out, 12) && $past(pace_port_clock_out, 6)
    && pace_port_clock_out[*6] ##1 !pace_port_clock_out)
    else $error("clock not high one period between words");
  a_low_half: assert property (
    $fell(pace_port_clock_out) |-> !pace_port_clock_out[*6] ##1 pace_port_clock_out)
    else $error("low half wrong");
  a_high_half: assert property (
    $rose(pace_port_clock_out) && !pace_port_select_n_out |-> pace_port_clock_out[*6])
    else $error("high half short");
  a_release_late: assert property (
    $rose(pace_port_select_n_out) |-> $past(pace_port_clock_out) && $past(pace_port_clock_out, 6))
    else $error("select released early");
  a_whole_words: assert property (
    $rose(pace_port_select_n_out) |-> falls_q != 0 && falls_q % 16 == 0)
    else $error("partial word");
  c_frame: cover property (frame_start_out);
  c_word_gap: cover property ($rose(pace_port_select_n_out) ##6 $fell(pace_port_select_n_out));
  c_packet: cover property ($rose(pace_port_select_n_out) && falls_q == 112);
endmodule : pace_port_props

bind pace_port_master pace_port_props #(
  .HALF_CYCLES(HALF_CYCLES), .FRAME_CYCLES(FRAME_CYCLES)) props_inst (
  .clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
  .acquisition_control_in(acquisition_control_in),
  .pace_port_select_n_out(pace_port_select_n_out), .pace_port_clock_out(pace_port_clock_out),
  .pace_port_data_out(pace_port_data_out), .frame_start_out(frame_start_out));

// >>> testbench/pace_port_receiver.sv
// receiver model of the external pace-detection processor
`timescale 1ns/1ps
module pace_port_receiver (
  // serial port
  input  wire logic   select_n_in,
  input  wire logic   clock_in,
  input  wire logic   data_in,
  // received frame
  output logic [15:0] word_out [7],
  output int          nframes_out,
  output int          nsel_out
);
  logic [15:0] sr;
  int          nbits = 0;
  int          nframes = 0;
  int          nsel = 0;
  assign nframes_out = nframes;
  assign nsel_out    = nsel;
  always @(posedge select_n_in) nsel++;
  always @(negedge clock_in) begin
    if (!select_n_in) begin
      sr = {sr[14:0], data_in};
      nbits++;
      if (nbits % 16 == 0)
        word_out[nbits / 16 - 1] = sr;
      if (nbits == 112) begin
        nbits = 0;
        nframes++;
      end
    end
  end
endmodule : pace_port_receiver

// >>> testbench/tb.sv
// testbench for the pace port master
`timescale 1ns/1ps
module tb;
  import pace_port_pkg::*;
  logic        clk_sys_in = 1'b0;
  logic        arst_n_in = 1'b0;
  logic [7:0]  acq = 8'h00;
  logic        mode = 1'b0;
  ecg_sample_t smp = '0;
  logic        sel_n, pclk, pdata, fstart;
  logic [15:0] rx [7];
  int          nfr, nsel;
  int          n_fail = 0;
  int          num_checks = 0;
  initial forever #2 clk_sys_in = ~clk_sys_in;
  pace_port_master #(.HEADER_WORD(16'h8000)) pace_port_master_inst (
    .clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .acquisition_control_in(acq),
    .per_word_select_mode_in(mode), .sample_in(smp), .pace_port_select_n_out(sel_n),
    .pace_port_clock_out(pclk), .pace_port_data_out(pdata), .frame_start_out(fstart));
  pace_port_receiver pace_port_receiver_inst (.select_n_in(sel_n), .clock_in(pclk),
    .data_in(pdata), .word_out(rx), .nframes_out(nfr), .nsel_out(nsel));
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  function automatic logic [15:0] crc_of(input logic [95:0] b);
    logic [15:0] c = 16'hffff;
    for (int i = 95; i >= 0; i--)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? 16'h1021 : 16'h0000);
    return c;
  endfunction : crc_of
  task automatic t_frame(input logic m, input ecg_sample_t s);
    int          f0;
    int          s0;
    int          k;
    logic [95:0] body;
    @(negedge clk_sys_in);
    acq = 8'h08;
    mode = m;
    smp = s;
    f0 = nfr;
    s0 = nsel;
    for (k = 0; k < 4000 && nfr == f0; k++) @(negedge clk_sys_in);
    repeat (40) @(negedge clk_sys_in);
    check(16'(nfr - f0), 16'h0001);
    body = {16'h8000, s, 32'h0};
    for (int i = 0; i < 6; i++)
      check(rx[i], body[95 - 16 * i -: 16]);
    check(rx[6], crc_of(body));
    check(16'(nsel - s0), m ? 16'h0007 : 16'h0001);
  endtask : t_frame
  task automatic t_disabled();
    int f0;
    @(negedge clk_sys_in);
    acq = 8'hf7;
    f0 = nfr;
    repeat (4000) @(negedge clk_sys_in);
    check(16'(nfr - f0), 16'h0000);
    check({15'h0, sel_n}, 16'h0001);
  endtask : t_disabled
  initial begin
    repeat (3) @(negedge clk_sys_in);
    arst_n_in = 1'b1;
    t_frame(1'b0, {16'h1234, 16'h8001, 16'hfffe});
    t_frame(1'b1, {16'h00ff, 16'hff00, 16'ha5a5});
    t_disabled();
    t_frame(1'b0, {16'h7fff, 16'h0001, 16'h5a5a});
    report_and_stop();
  end
  initial begin
    #160000;
    n_fail++;
    report_and_stop();
  end
endmodule : tb
